// file: inc/cptd_defs.svh
// Purpose: Timing counts and constants for the call progress detect back end
// Assumes: 10 MHz system clock
// Notes: Times kept in their own units; cycle counts derived from them
`ifndef CPTD_DEFS_SVH
`define CPTD_DEFS_SVH

// ****************************************
// Timing
// ****************************************
`define CPTD_CLK_HZ 10000000
`define CPTD_TICK_US 1000
`define CPTD_TICK_CYC (`CPTD_CLK_HZ / 1000000 * `CPTD_TICK_US)
`define CPTD_DETECT_MS 200
`define CPTD_REJECT_MS 160
`define CPTD_BRIDGE_MS 30
`define CPTD_RELEASE_MS 200
`define CPTD_ON_MS 180
`define CPTD_OFF_MS 40
`define CPTD_CH_NUM 4
`define CPTD_MS_W 8
`define CPTD_PULSE_MS 2

`endif

// file: inc/cptd_pkg.sv
// Purpose: Types for the call progress detect back end
// Assumes: Constants come from cptd_defs.svh
// Notes: One timing state per channel
package cptd_pkg;
  typedef enum logic [2:0] {
    CPTD_IDLE = 3'h1,
    CPTD_QUAL = 3'h2,
    CPTD_HELD = 3'h4
  } cptd_state_t;

  typedef struct packed {
    logic [3:0] det;
    logic anyTone;
  } cptd_out_t;
endpackage

// file: hw/cptd_detect.sv
// Purpose: Tone duration timing, demultiplex and output enables, four channels
// Assumes: Front end gives time-multiplexed tone pulses with a channel index
// Notes: Tristate pins are split into value and enable signals
//
// What this block does
// - Detect outputs driven while detect enable high, floated while low.
// - A detect output rises only after valid tone on that channel.
// - Any-tone flag is the OR of the four channel detect results.
// - Flag ignores detect enable; floats only when its own enable low.
// - Variant parameter selects 350/400/440/480 or 350/440/480/620 Hz channels.
// - Millisecond ticks are counted while tone pulses keep arriving, to time tone duration.
// - Tones of 200 ms or more detected, output up within 200 ms.
// - Bursts under 150 ms rejected, as the count runs on through the 30 ms bridge; release within 200 ms of tone end.
// - Dropouts up to 30 ms are bridged without dropping the output.
// - Shared pulse path demultiplexed to four distinct detect outputs.
// - All timing derived from the 10 MHz system clock; the 3.58 MHz base is only mirrored.
// - Oscillator frequency mirrored on clock buffer output when crystal runs.
`timescale 1ns/1ps
`include "cptd_defs.svh"

module cptd_detect #(
  parameter bit VARIANT_B = 1'b0, // 0: 350/400/440/480 Hz, 1: 350/440/480/620 Hz
  parameter int unsigned TICK_CYC = `CPTD_TICK_CYC // Clocks per ms tick; a bench may shorten it
) (
  input wire logic clk, // 10 MHz clock
  input wire logic resetn, // Async reset, active low
  input wire logic tonePulse, // Peak detector pulse, asynchronous
  input wire logic [1:0] pulseChan, // Channel of the shared pulse, asynchronous
  input wire logic detectEnable, // Detect output enable pin
  input wire logic flagEnable, // Flag output enable pin
  input wire logic oscRunning, // Crystal oscillator active
  input wire logic timeBase, // 3.58 MHz base, crystal or external
  output logic [3:0] tone_detect_out, // Detect pin values
  output logic [3:0] detectOe, // Detect pin enables
  output logic anyToneOut, // Flag pin value
  output logic anyToneOe, // Flag pin enable
  output logic clock_buffer_out, // Buffered oscillator
  output logic [39:0] chanFreqHz // Channel tone map, 10 bits each
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [2:0] syncA_reg, syncB_reg, sync_next;
  logic [2:0] ctlA_reg, ctlB_reg, ctl_next;
  logic tbA_reg, tbB_reg;
  // Pins come from outside the clock domain; the channel index rides in the
  // same stages as the pulse, as it is held steady around the pulse edge
  always_comb begin
    sync_next = {tonePulse, pulseChan};
    ctl_next = {detectEnable, flagEnable, oscRunning};
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      syncA_reg <= 3'h0;
      syncB_reg <= 3'h0;
      ctlA_reg <= 3'h0;
      ctlB_reg <= 3'h0;
      tbA_reg <= 1'b0;
      tbB_reg <= 1'b0;
    end else begin
      syncA_reg <= sync_next;
      syncB_reg <= syncA_reg;
      ctlA_reg <= ctl_next;
      ctlB_reg <= ctlA_reg;
      tbA_reg <= timeBase;
      tbB_reg <= tbA_reg;
    end
  end

  // ****************************************
  // Pulse edge and millisecond tick
  // ****************************************
  logic pulsePrev_reg, pulsePrev_next;
  logic [15:0] tickCnt_reg, tickCnt_next;
  logic msTick;
  logic pulseRise;
  // Tick from the system clock; the base itself is only mirrored, since
  // 3.58 MHz cannot be sampled cleanly at 10 MHz for exact timing
  always_comb begin
    pulsePrev_next = syncB_reg[2];
    pulseRise = syncB_reg[2] & ~pulsePrev_reg;
    msTick = (tickCnt_reg == 16'(TICK_CYC - 1));
    tickCnt_next = msTick ? 16'h0000 : tickCnt_reg + 16'h0001;
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pulsePrev_reg <= 1'b0;
      tickCnt_reg <= 16'h0000;
    end else begin
      pulsePrev_reg <= pulsePrev_next;
      tickCnt_reg <= tickCnt_next;
    end
  end

  // ****************************************
  // Per-channel timing state
  // ****************************************
  cptd_pkg::cptd_state_t st_reg [4];
  cptd_pkg::cptd_state_t st_next [4];
  logic [7:0] onMs_reg [4], onMs_next [4];
  logic [7:0] offMs_reg [4], offMs_next [4];
  logic [3:0] det_reg, det_next;
  logic [3:0] hit;

  // Demultiplex the shared pulse to its channel, then time each on its own
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      hit[c] = pulseRise && (syncB_reg[1:0] == 2'(c));
      st_next[c] = st_reg[c];
      onMs_next[c] = onMs_reg[c];
      offMs_next[c] = offMs_reg[c];
      det_next[c] = det_reg[c];
      if (hit[c]) begin
        offMs_next[c] = 8'h00;
      end else if (msTick && offMs_reg[c] != 8'hff) begin
        offMs_next[c] = offMs_reg[c] + 8'h01;
      end
      case (st_reg[c])
        cptd_pkg::CPTD_IDLE: begin
          onMs_next[c] = 8'h00;
          if (hit[c]) begin
            st_next[c] = cptd_pkg::CPTD_QUAL;
          end
        end
        cptd_pkg::CPTD_QUAL: begin
          // Pulses must keep arriving; a gap over the bridge time restarts
          if (msTick) begin
            onMs_next[c] = onMs_reg[c] + 8'h01;
          end
          if (offMs_reg[c] > 8'(`CPTD_BRIDGE_MS)) begin
            st_next[c] = cptd_pkg::CPTD_IDLE;
          end else if (onMs_reg[c] >= 8'(`CPTD_ON_MS)) begin
            st_next[c] = cptd_pkg::CPTD_HELD; // 180 ms lies in 160..200
            det_next[c] = 1'b1;
          end
        end
        cptd_pkg::CPTD_HELD: begin
          // Gaps up to 30 ms kept; 40 ms of silence releases
          if (offMs_reg[c] >= 8'(`CPTD_OFF_MS)) begin
            st_next[c] = cptd_pkg::CPTD_IDLE;
            det_next[c] = 1'b0;
          end
        end
        default: begin
          st_next[c] = cptd_pkg::CPTD_IDLE;
          det_next[c] = 1'b0;
        end
      endcase
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int c = 0; c < 4; c++) begin
        st_reg[c] <= cptd_pkg::CPTD_IDLE;
        onMs_reg[c] <= 8'h00;
        offMs_reg[c] <= 8'hff;
      end
      det_reg <= 4'h0;
    end else begin
      for (int c = 0; c < 4; c++) begin
        st_reg[c] <= st_next[c];
        onMs_reg[c] <= onMs_next[c];
        offMs_reg[c] <= offMs_next[c];
      end
      det_reg <= det_next;
    end
  end

  // ****************************************
  // Output pins
  // ****************************************
  cptd_pkg::cptd_out_t out_next;
  logic [3:0] oe_next;
  logic aoe_next, clkb_next;
  logic [39:0] freq_next;
  always_comb begin
    out_next.det = det_reg;
    out_next.anyTone = |det_reg;
    oe_next = {4{ctlB_reg[2]}};
    aoe_next = ctlB_reg[1];
    clkb_next = ctlB_reg[0] & tbB_reg; // coarse copy at 10 MHz sampling
    freq_next = VARIANT_B ? {10'h26c, 10'h1e0, 10'h1b8, 10'h15e}
                          : {10'h1e0, 10'h1b8, 10'h190, 10'h15e};
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tone_detect_out <= 4'h0;
      detectOe <= 4'h0;
      anyToneOut <= 1'b0;
      anyToneOe <= 1'b0;
      clock_buffer_out <= 1'b0;
      chanFreqHz <= 40'h0;
    end else begin
      tone_detect_out <= out_next.det;
      detectOe <= oe_next;
      anyToneOut <= out_next.anyTone;
      anyToneOe <= aoe_next;
      clock_buffer_out <= clkb_next;
      chanFreqHz <= freq_next;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  AST_DET_OE: assert property (@(posedge clk) disable iff (!resetn)
    detectOe == {4{$past(ctlB_reg[2])}}) else $error("detect enable wrong");
  AST_RISE_CAUSE: assert property (@(posedge clk) disable iff (!resetn)
    $rose(det_reg[0]) |-> $past(st_reg[0]) == cptd_pkg::CPTD_QUAL)
    else $error("detect rose without qualify");
  AST_ANY_OR: assert property (@(posedge clk) disable iff (!resetn)
    anyToneOut == |$past(det_reg)) else $error("flag not OR of detects");
  AST_FLAG_OE: assert property (@(posedge clk) disable iff (!resetn)
    anyToneOe == $past(ctlB_reg[1])) else $error("flag enable wrong");
  AST_QUAL_TIME: assert property (@(posedge clk) disable iff (!resetn)
    $rose(det_reg[1]) |-> $past(onMs_reg[1]) >= 8'(`CPTD_REJECT_MS)
      && $past(onMs_reg[1]) < 8'(`CPTD_DETECT_MS))
    else $error("qualify time out of window");
  AST_BRIDGE: assert property (@(posedge clk) disable iff (!resetn)
    $fell(det_reg[2]) |-> $past(offMs_reg[2]) > 8'(`CPTD_BRIDGE_MS))
    else $error("dropout not bridged");
  AST_RELEASE: assert property (@(posedge clk) disable iff (!resetn)
    det_reg[3] |-> offMs_reg[3] <= 8'(`CPTD_OFF_MS)) else $error("release late");
  AST_TICK: assert property (@(posedge clk) disable iff (!resetn)
    msTick |=> !msTick [*8]) else $error("tick too often");
  AST_CLKBUF: assert property (@(posedge clk) disable iff (!resetn)
    !$past(ctlB_reg[0]) |-> !clock_buffer_out) else $error("clock out while off");
  COV_DETECT: cover property (@(posedge clk) disable iff (!resetn) $rose(det_reg[0]));
  COV_RELEASE: cover property (@(posedge clk) disable iff (!resetn) $fell(det_reg[1]));
  COV_REJECT: cover property (@(posedge clk) disable iff (!resetn)
    st_reg[2] == cptd_pkg::CPTD_QUAL ##1 st_reg[2] == cptd_pkg::CPTD_IDLE);
endmodule

// file: bench/cptd_front_model.sv
// Purpose: Behavioural model of the analog front end feeding the detect back end
// Assumes: Called from the bench thread, so its random draws follow the bench seed
// Notes: Pulses are at least two cycles high and low; idle channel index scrambles
`timescale 1ns/1ps

module cptd_front_model (
  input wire logic clk, // System clock
  output logic tonePulse, // Peak detector pulse
  output logic [1:0] pulseChan, // Channel of the pulse
  output logic timeBase // 3.58 MHz base
);
  logic busy = 1'b0;

  initial begin
    tonePulse = 1'b0;
    pulseChan = 2'h0;
    timeBase = 1'b0;
  end

  // Square wave at 50 percent duty, inside the allowed duty band
  always #139.665 timeBase = ~timeBase;

  // Idle index keeps moving so a stale channel is never trusted
  always @(posedge clk) begin
    if (!busy) begin
      pulseChan <= pulseChan + 2'h1;
    end
  end

  // Burst of n pulses on one channel, or on random channels when mixed
  task automatic burst(input int n, input logic [1:0] ch, input bit mixed);
    busy = 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      #1 pulseChan = mixed ? 2'($urandom_range(3)) : ch;
      repeat (2) @(posedge clk);
      #1 tonePulse = 1'b1;
      repeat (2 + $urandom_range(8)) @(posedge clk);
      #1 tonePulse = 1'b0;
    end
    busy = 1'b0;
  endtask
endmodule

// file: bench/test_call_progress_detect_outputs.sv
// Purpose: Self-checking bench for the call progress detect back end
// Assumes: Millisecond tick shortened to 20 clocks so whole tones fit the run budget
// Notes: Covers enables, tone map, clock mirror, short-burst rejection per channel
`timescale 1ns/1ps

module test_call_progress_detect_outputs;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic detectEnable = 1'b0;
  logic flagEnable = 1'b0;
  logic oscRunning = 1'b0;
  logic tonePulse, timeBase, anyToneOut, anyToneOe, clock_buffer_out;
  logic [1:0] pulseChan;
  logic [3:0] tone_detect_out, detectOe;
  logic [39:0] freqA, freqB;
  logic sawDet = 1'b0;
  logic watchRej = 1'b0;
  int mismatches = 0;
  int n_compared = 0;

  always #50 clk = ~clk;

  cptd_front_model fe (.clk(clk), .tonePulse(tonePulse), .pulseChan(pulseChan),
    .timeBase(timeBase));
  // Short tick: one timing millisecond is 20 clocks here, the logic is unchanged
  cptd_detect #(.VARIANT_B(1'b0), .TICK_CYC(20)) dut (.clk(clk), .resetn(resetn),
    .tonePulse(tonePulse),
    .pulseChan(pulseChan), .detectEnable(detectEnable), .flagEnable(flagEnable),
    .oscRunning(oscRunning), .timeBase(timeBase), .tone_detect_out(tone_detect_out),
    .detectOe(detectOe), .anyToneOut(anyToneOut), .anyToneOe(anyToneOe),
    .clock_buffer_out(clock_buffer_out), .chanFreqHz(freqA));
  cptd_detect #(.VARIANT_B(1'b1)) dutB (.clk(clk), .resetn(resetn), .tonePulse(tonePulse),
    .pulseChan(pulseChan), .detectEnable(detectEnable), .flagEnable(flagEnable),
    .oscRunning(oscRunning), .timeBase(timeBase), .tone_detect_out(),
    .detectOe(), .anyToneOut(), .anyToneOe(), .clock_buffer_out(), .chanFreqHz(freqB));

  // Sticky flag: short bursts must never raise a detect or the flag
  always @(negedge clk) begin
    if (resetn && watchRej && (tone_detect_out !== 4'h0 || anyToneOut !== 1'b0)) begin
      sawDet <= 1'b1;
    end
  end

  // Expected tone map, channel 0 in the low ten bits
  function automatic logic [39:0] exp_freq(input bit b);
    return b ? {10'h26c, 10'h1e0, 10'h1b8, 10'h15e} : {10'h1e0, 10'h1b8, 10'h190, 10'h15e};
  endfunction

  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Enables: four corners first, then random; enable settles within four edges
  task automatic test_enables;
    logic de, fl;
    for (int i = 0; i < 16; i++) begin
      de = (i < 4) ? i[0] : 1'($urandom_range(1));
      fl = (i < 4) ? i[1] : 1'($urandom_range(1));
      detectEnable = de;
      flagEnable = fl;
      step(4);
      check(40'(detectOe), 40'({4{de}}));
      check(40'(anyToneOe), 40'(fl));
    end
    resetn = 1'b0;
    step(1);
    check(40'({detectOe, anyToneOe, tone_detect_out}), 40'h0);
    resetn = 1'b1;
    $display("test enables done");
  endtask

  // Mirror must toggle while the oscillator runs
  task automatic test_mirror;
    int ones;
    ones = 0;
    oscRunning = 1'b1;
    step(4);
    repeat (40) begin
      step(1);
      ones += (clock_buffer_out === 1'b1) ? 1 : 0;
    end
    check(40'(ones > 4 && ones < 36), 40'h1);
    $display("test mirror done");
  endtask

  // One channel: short burst rejected, long tone up within 200 ms, held, released
  task automatic test_channel(input logic [1:0] c);
    logic [3:0] exp;
    exp = 4'h1 << c;
    watchRej = 1'b1;
    fe.burst(200, c, 1'b0);
    step(700);
    watchRej = 1'b0;
    check(40'(tone_detect_out), 40'h0);
    fork
      fe.burst(800, c, 1'b0);
      begin
        step(4006);
        check(40'(tone_detect_out), 40'(exp));
      end
    join
    step(600);
    check(40'(tone_detect_out), 40'(exp));
    check(40'(anyToneOut), 40'h1);
    step(3400);
    check(40'(tone_detect_out), 40'h0);
    $display("test channel %0d done", c);
  endtask

  initial begin
    void'($urandom(74856));
    step(12);
    resetn = 1'b1;
    step(2);
    check(freqA, exp_freq(1'b0));
    check(freqB, exp_freq(1'b1));
    check(40'(clock_buffer_out), 40'h0);
    test_enables();
    test_mirror();
    detectEnable = 1'b1;
    flagEnable = 1'b1;
    for (int c = 0; c < 4; c++) begin
      test_channel(2'(c));
    end
    // Mixed channels: all four run their own timing at once
    fe.burst(1000, 2'h0, 1'b1);
    step(5);
    check(40'(tone_detect_out), 40'hf);
    check(40'(anyToneOut), 40'h1);
    step(4000);
    check(40'({tone_detect_out, anyToneOut}), 40'h0);
    check(40'(sawDet), 40'h0);
    $display("test bursts done");
    wrap_up();
  end

  // Run limit of 95000 clocks, above the worst-case length of the scenarios
  initial begin
    #9500000;
    mismatches++;
    $display("[ERR] %0t run limit reached", $time);
    wrap_up();
  end
endmodule
